// ---- cme_edge_if.sv ----
// filtered levels and edge strobes of one timer's two sense inputs
`timescale 1ns/1ps
`default_nettype none
interface cme_edge_if;
  logic [1:0] level;
  logic [1:0] rise;
  logic [1:0] fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface
`default_nettype wire

// ---- cme_pkg.sv ----
// types shared by the count control block
`default_nettype none
package cme_pkg;
  typedef logic [7:0] cme_ctrl_t;
  typedef logic [1:0] cme_pair_t;
endpackage
`default_nettype wire

// ---- cme_pulse_src.sv ----
// far-side pulse sources that drive the four sense pins
`timescale 1ns/1ps
`default_nettype none
module cme_pulse_src (
  input  wire logic       i_clock,
  output var  logic [3:0] o_sense
);
  // ------------------------------------------------------------------
  // pin levels, all low when idle
  // ------------------------------------------------------------------
  initial begin
    o_sense = 4'h0;
  end

  // change one pin just after an edge, then hold the level two cycles
  // so the sampler in the block cannot miss it
  task automatic drive(input int idx, input logic lvl);
    @(posedge i_clock);
    o_sense[idx] <= lvl;
    repeat (2) @(posedge i_clock);
  endtask
endmodule
`default_nettype wire

// ---- cme_regs.svh ----
// register addresses, field positions and reset values of the count control
`ifndef CME_REGS_SVH
`define CME_REGS_SVH

// ----------------------------------------------------------------------------
// byte addresses on the register bus
// ----------------------------------------------------------------------------
`define CME_ADDR_CTRL_T0   32'h4000_c070
`define CME_ADDR_CTRL_T1   32'h4001_0070
`define CME_ADDR_STATUS    32'h4000_c0fc

// ----------------------------------------------------------------------------
// count control register fields
// ----------------------------------------------------------------------------
`define CME_CTRL_W         8
`define CME_MODE_F         1:0
`define CME_CIS_F          3:2
`define CME_EDGE_CLEAR_ENABLE_BIT       4
`define CME_CLEAR_EDGE_SELECT_F        7:5
`define CME_CTRL_RST       8'h00
`define CME_MODE_TIMER     2'h0
`define CME_MODE_RISE      2'h1
`define CME_MODE_FALL      2'h2
`define CME_MODE_BOTH      2'h3

// ----------------------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------------------
`define CME_RESP_OKAY      2'h0
`define CME_RESP_SLVERR    2'h2

`endif

// ---- cme_sense_sync.sv ----
// three-stage sampler and edge classifier for two sense pins
`timescale 1ns/1ps
`default_nettype none
module cme_sense_sync
  import cme_pkg::*;
(
  input  wire logic      i_clock,
  input  wire logic      i_reset,
  input  wire cme_pair_t i_sense,
  cme_edge_if.src        edges
);

  cme_pair_t s1_r;
  cme_pair_t s2_r;
  cme_pair_t s3_r;
  cme_pair_t lvl_r;

  // ------------------------------------------------------------------------
  // sampling chain, the first stage feeds only the second
  // ------------------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      s1_r <= 2'h0;
      s2_r <= 2'h0;
      s3_r <= 2'h0;
    end else begin
      s1_r <= i_sense;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // ------------------------------------------------------------------------
  // accepted level moves only when stages two and three agree
  // ------------------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      lvl_r <= 2'h0;
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (s2_r[k] == s3_r[k]) begin
          lvl_r[k] <= s3_r[k]; // RULE_17
        end
      end
    end
  end

  // compare accepted level with the agreed new sample
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      edges.rise[k] = (s2_r[k] & s3_r[k]) & ~lvl_r[k]; // RULE_18
      edges.fall[k] = ~(s2_r[k] | s3_r[k]) & lvl_r[k]; // RULE_18
    end
    edges.level = lvl_r;
  end

endmodule
`default_nettype wire

// ---- cme_top.sv ----
// count mode and edge clear control for two 16-bit timers, AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "cme_regs.svh"

// Function
// RULE_01: enabled edge clear uses select field code
// RULE_02: select field ignored while clear disabled
// RULE_03: timer0 codes 0/1 clear on input0 edges
// RULE_04: timer0 codes 4/5 clear on input1 edges
// RULE_05: software avoids timer0 reserved clear codes
// RULE_06: software writes zeros to upper bits
// RULE_07: upper bits read value is undefined
// RULE_08: mode field picks advance or clear edges
// RULE_09: mode 0 advances prescaler every clock
// RULE_10: mode 1 counts selected input rising edges
// RULE_11: mode 2 counts selected input falling edges
// RULE_12: mode 3 counts both input edges
// RULE_13: counter mode needs capture control low zero
// RULE_14: timer1 input select 0/1 picks input
// RULE_15: software avoids timer1 reserved input codes
// RULE_16: edge clear resets count and prescaler
// RULE_17: selected input sampled every clock edge
// RULE_18: two samples classify edge, matching mode counts
// RULE_19: timer0 input select 0/2, others reserved
// RULE_20: timer1 clear codes 0-3 pick input edges
// RULE_21: reserved clear code never clears
// RULE_22: fields reset to zero, timer mode
module cme_top
  import cme_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  input  wire logic [31:0] i_s_axi_awaddr,
  input  wire logic        i_s_axi_awvalid,
  output var  logic        o_s_axi_awready,
  input  wire logic [31:0] i_s_axi_wdata,
  input  wire logic [3:0]  i_s_axi_wstrb,
  input  wire logic        i_s_axi_wvalid,
  output var  logic        o_s_axi_wready,
  output var  logic [1:0]  o_s_axi_bresp,
  output var  logic        o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  input  wire logic [31:0] i_s_axi_araddr,
  input  wire logic        i_s_axi_arvalid,
  output var  logic        o_s_axi_arready,
  output var  logic [31:0] o_s_axi_rdata,
  output var  logic [1:0]  o_s_axi_rresp,
  output var  logic        o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready,
  input  wire logic        i_timer0_sense0,
  input  wire logic        i_timer0_sense1,
  input  wire logic        i_timer1_sense0,
  input  wire logic        i_timer1_sense1,
  output var  logic [1:0]  o_prescale_adv,
  output var  logic [1:0]  o_count_adv,
  output var  logic [1:0]  o_edge_clear
);

  // ------------------------------------------------------------------------
  // decode helpers, each used for both timers
  // ------------------------------------------------------------------------

  // counter mode event on the selected input; reserved selects never count
  function automatic logic count_hit(input logic      inst,
                                     input cme_ctrl_t c,
                                     input cme_pair_t r,
                                     input cme_pair_t f);
    logic [1:0] count_input_select;
    logic       ok;
    logic       pin;
    logic       hit;
    count_input_select = c[`CME_CIS_F];
    if (!inst) begin
      ok  = ~count_input_select[0];    // codes 0 and 2
      pin = count_input_select[1];
    end else begin
      ok  = ~count_input_select[1];    // codes 0 and 1
      pin = count_input_select[0];
    end
    case (c[`CME_MODE_F])
      `CME_MODE_RISE: hit = r[pin];
      `CME_MODE_FALL: hit = f[pin];
      `CME_MODE_BOTH: hit = r[pin] | f[pin];
      default:        hit = 1'b0;
    endcase
    return ok & hit;
  endfunction

  // clearing edge per select code; bit 0 of the code picks the falling edge
  function automatic logic clear_hit(input logic      inst,
                                     input cme_ctrl_t c,
                                     input cme_pair_t r,
                                     input cme_pair_t f);
    logic [2:0] sel;
    logic       ok;
    logic       pin;
    sel = c[`CME_CLEAR_EDGE_SELECT_F];
    if (!inst) begin
      ok  = ~sel[1];    // codes 0,1,4,5
      pin = sel[2];
    end else begin
      ok  = ~sel[2];    // codes 0..3
      pin = sel[1];
    end
    return ok & (sel[0] ? f[pin] : r[pin]);
  endfunction

  // ------------------------------------------------------------------------
  // sense input conditioning
  // ------------------------------------------------------------------------
  cme_edge_if ed0 ();
  cme_edge_if ed1 ();

  cme_sense_sync u_sync0 (
    .i_clock (i_clock),
    .i_reset (i_reset),
    .i_sense ({i_timer0_sense1, i_timer0_sense0}),
    .edges   (ed0)
  );

  cme_sense_sync u_sync1 (
    .i_clock (i_clock),
    .i_reset (i_reset),
    .i_sense ({i_timer1_sense1, i_timer1_sense0}),
    .edges   (ed1)
  );

  cme_pair_t rise_a [2];
  cme_pair_t fall_a [2];
  assign rise_a[0] = ed0.rise;
  assign rise_a[1] = ed1.rise;
  assign fall_a[0] = ed0.fall;
  assign fall_a[1] = ed1.fall;

  // ------------------------------------------------------------------------
  // register file and bus slave state
  // ------------------------------------------------------------------------
  cme_ctrl_t   ctrl_r [2];
  logic [31:0] waddr_r;
  logic [7:0]  wbyte_r;
  logic        wlane_r;
  logic        do_write;
  logic        aw_hit;

  // both halves of a write are held once each ready has dropped
  assign do_write = ~o_s_axi_awready & ~o_s_axi_wready & ~o_s_axi_bvalid;
  assign aw_hit   = (waddr_r == `CME_ADDR_CTRL_T0) ||
                    (waddr_r == `CME_ADDR_CTRL_T1);

  // address and data channels are taken independently, in either order
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_s_axi_awready <= 1'b1;
      o_s_axi_wready  <= 1'b1;
      waddr_r         <= 32'h0000_0000;
      wbyte_r         <= 8'h00;
      wlane_r         <= 1'b0;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        o_s_axi_awready <= 1'b0;
        waddr_r         <= i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        o_s_axi_wready <= 1'b0;
        wbyte_r        <= i_s_axi_wdata[7:0]; // upper bits are not stored
        wlane_r        <= i_s_axi_wstrb[0];
      end
      if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_awready <= 1'b1;
        o_s_axi_wready  <= 1'b1;
      end
    end
  end

  // write response, unmapped addresses answer with a slave error
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp  <= `CME_RESP_OKAY;
    end else if (do_write) begin
      o_s_axi_bvalid <= 1'b1;
      o_s_axi_bresp  <= aw_hit ? `CME_RESP_OKAY : `CME_RESP_SLVERR;
    end else if (o_s_axi_bvalid && i_s_axi_bready) begin
      o_s_axi_bvalid <= 1'b0;
    end
  end

  // control registers; only the low byte lane carries implemented bits
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      ctrl_r[0] <= `CME_CTRL_RST; // RULE_22
      ctrl_r[1] <= `CME_CTRL_RST; // RULE_22
    end else if (do_write && wlane_r) begin
      if (waddr_r == `CME_ADDR_CTRL_T0) begin
        ctrl_r[0] <= wbyte_r;
      end
      if (waddr_r == `CME_ADDR_CTRL_T1) begin
        ctrl_r[1] <= wbyte_r;
      end
    end
  end

  // read channel, one outstanding read; upper bits read as zero
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_s_axi_arready <= 1'b1;
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_rdata   <= 32'h0000_0000;
      o_s_axi_rresp   <= `CME_RESP_OKAY;
    end else if (i_s_axi_arvalid && o_s_axi_arready) begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid  <= 1'b1;
      o_s_axi_rresp   <= `CME_RESP_OKAY;
      case (i_s_axi_araddr)
        `CME_ADDR_CTRL_T0: o_s_axi_rdata <= {24'h00_0000, ctrl_r[0]};
        `CME_ADDR_CTRL_T1: o_s_axi_rdata <= {24'h00_0000, ctrl_r[1]};
        `CME_ADDR_STATUS:  o_s_axi_rdata <= {28'h000_0000, ed1.level,
                                             ed0.level};
        default: begin
          o_s_axi_rdata <= 32'h0000_0000;
          o_s_axi_rresp <= `CME_RESP_SLVERR;
        end
      endcase
    end else if (o_s_axi_rvalid && i_s_axi_rready) begin
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_arready <= 1'b1;
    end
  end

  // ------------------------------------------------------------------------
  // count steering toward the prescaler and timer count
  // ------------------------------------------------------------------------

  // registered so the downstream counters see glitch-free strobes
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_prescale_adv <= 2'h0;
      o_count_adv    <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        // timer mode: each clock edge may advance the prescaler
        o_prescale_adv[i] <= (ctrl_r[i][`CME_MODE_F] ==
                              `CME_MODE_TIMER); // RULE_08 RULE_09
        // counter mode: prescaler does not advance, matching edge advances count
        o_count_adv[i] <= count_hit(1'(i), ctrl_r[i], rise_a[i],
                                    fall_a[i]); // RULE_10 RULE_11 RULE_12 RULE_14 RULE_19
      end
    end
  end

  // edge clear; reserved codes and a low enable never fire
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_edge_clear <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        o_edge_clear[i] <= ctrl_r[i][`CME_EDGE_CLEAR_ENABLE_BIT] &&
                           clear_hit(1'(i), ctrl_r[i], rise_a[i],
                                     fall_a[i]); // RULE_01 RULE_02 RULE_03 RULE_04 RULE_16 RULE_20 RULE_21
      end
    end
  end

  // ------------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  chk_timer_every_edge: assert property ( // RULE_09
    ctrl_r[0][`CME_MODE_F] == `CME_MODE_TIMER [*2] |=> o_prescale_adv[0]
  ) else $error("timer mode did not advance prescaler");

  chk_clear_needs_enable: assert property ( // RULE_02
    !ctrl_r[1][`CME_EDGE_CLEAR_ENABLE_BIT] |=> !o_edge_clear[1]
  ) else $error("edge clear fired while disabled");

  chk_t0_rise_clear: assert property ( // RULE_03
    ctrl_r[0][7:4] == 4'h1 && ed0.rise[0] |=> o_edge_clear[0]
  ) else $error("timer0 rising clear on input0 missed");

  chk_t0_fall1_clear: assert property ( // RULE_04
    ctrl_r[0][7:4] == 4'hb && ed0.fall[1] |=> o_edge_clear[0]
  ) else $error("timer0 falling clear on input1 missed");

  chk_reserved_no_clear: assert property ( // RULE_21
    ctrl_r[0][6] |=> !o_edge_clear[0]
  ) else $error("reserved clear code produced a clear");

  chk_t1_rise_count: assert property ( // RULE_10
    ctrl_r[1][3:0] == 4'h5 && ed1.rise[1] |=> o_count_adv[1]
  ) else $error("timer1 rising count on input1 missed");

  chk_fall_ignores_rise: assert property ( // RULE_11
    ctrl_r[1][`CME_MODE_F] == `CME_MODE_FALL && !(|ed1.fall)
      |=> !o_count_adv[1]
  ) else $error("falling mode counted without a falling edge");

  chk_both_edges: assert property ( // RULE_12
    ctrl_r[0][3:0] == 4'hb && (ed0.rise[1] || ed0.fall[1])
      |=> o_count_adv[0] && !o_prescale_adv[0]
  ) else $error("both-edge mode missed an edge");

  chk_t0_reserved_cis: assert property ( // RULE_19
    ctrl_r[0][2] |=> !o_count_adv[0]
  ) else $error("reserved input select counted");

  chk_t1_clear_fall1: assert property ( // RULE_20
    ctrl_r[1][7:4] == 4'h7 && ed1.fall[1] |=> o_edge_clear[1]
  ) else $error("timer1 clear code 3 missed");

  chk_pin_to_count: assert property ( // RULE_17
    ctrl_r[1][3:0] == 4'h1 [*6] ##0 $rose(ed1.level[0])
      |-> o_count_adv[1]
  ) else $error("accepted rising level did not count");

  chk_reset_timer_mode: assert property (disable iff (1'b0) // RULE_22
    i_reset |=> ctrl_r[0] == 8'h00 && ctrl_r[1] == 8'h00
  ) else $error("control not cleared by reset");

  chk_bvalid_held: assert property (
    o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid
  ) else $error("write response dropped before taken");

  cov_edge_clear: cover property (o_edge_clear[0] ##1 o_edge_clear[1]);
  cov_counter_adv: cover property (o_count_adv[1]);
  cov_write_done: cover property (o_s_axi_bvalid && i_s_axi_bready);
  cov_read_done:  cover property (o_s_axi_rvalid && i_s_axi_rready);

endmodule
`default_nettype wire

// ---- cme_top_bench.sv ----
// self-checking bench for the count mode and edge clear block
`timescale 1ns/1ps
`default_nettype none
`include "cme_regs.svh"
module cme_top_bench;
  import cme_pkg::*;
  logic i_clock, i_reset;
  logic [31:0] i_s_axi_awaddr, i_s_axi_wdata, i_s_axi_araddr, o_s_axi_rdata;
  logic [3:0] i_s_axi_wstrb;
  logic i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready;
  logic i_s_axi_arvalid, i_s_axi_rready;
  logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid;
  logic o_s_axi_arready, o_s_axi_rvalid;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
  logic [1:0] o_prescale_adv, o_count_adv, o_edge_clear;
  logic [3:0] sense;
  int n_mismatch, n_tests, cycles;
  int n_adv[2];
  int n_clr[2];

  cme_top cme_top_i (.i_clock, .i_reset, .i_s_axi_awaddr, .i_s_axi_awvalid,
    .o_s_axi_awready, .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid,
    .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready,
    .i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata,
    .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready,
    .i_timer0_sense0(sense[0]), .i_timer0_sense1(sense[1]),
    .i_timer1_sense0(sense[2]), .i_timer1_sense1(sense[3]),
    .o_prescale_adv, .o_count_adv, .o_edge_clear);
  cme_pulse_src cme_pulse_src_i (.i_clock(i_clock), .o_sense(sense));

  // ------------------------------------------------------------------
  // clock, strobe counters and hang guard
  // ------------------------------------------------------------------
  initial i_clock = 1'b0;
  always #5 i_clock = ~i_clock;
  // strobes are one-cycle pulses, so counting them per timer is exact
  always @(posedge i_clock) begin
    cycles++;
    for (int t = 0; t < 2; t++) begin
      if (o_count_adv[t] === 1'b1) n_adv[t]++;
      if (o_edge_clear[t] === 1'b1) n_clr[t]++;
    end
    if (cycles == 5000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // ------------------------------------------------------------------
  // register bus master
  // ------------------------------------------------------------------
  // waits are open ended; only the cycle ceiling above ends a hang
  task automatic axi_wr(input logic [31:0] a, d, output logic [1:0] rs);
    @(posedge i_clock);
    i_s_axi_awaddr <= a;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wdata <= d;
    i_s_axi_wstrb <= 4'hf;
    i_s_axi_wvalid <= 1'b1;
    i_s_axi_bready <= 1'b1;
    do begin
      @(posedge i_clock);
      if (i_s_axi_awvalid && o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
      if (i_s_axi_wvalid && o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
    end while (!(i_s_axi_bready && o_s_axi_bvalid === 1'b1));
    rs = o_s_axi_bresp;
    i_s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d,
                        output logic [1:0] rs);
    @(posedge i_clock);
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_rready <= 1'b1;
    do begin
      @(posedge i_clock);
      if (i_s_axi_arvalid && o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
    end while (!(i_s_axi_rready && o_s_axi_rvalid === 1'b1));
    d = o_s_axi_rdata;
    rs = o_s_axi_rresp;
    i_s_axi_rready <= 1'b0;
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  // reset state, unmapped place and read-only status
  task automatic reset_and_map();
    logic [31:0] d;
    logic [1:0] rs;
    check("prescale_adv", 32'(o_prescale_adv), 32'h0000_0003);
    axi_rd(`CME_ADDR_CTRL_T0, d, rs);
    check("ctrl_t0", 32'(d[7:0]), 32'h0000_0000);
    axi_rd(`CME_ADDR_CTRL_T1, d, rs);
    check("ctrl_t1", 32'(d[7:0]), 32'h0000_0000);
    axi_rd(32'h4000_c000, d, rs);
    check("rresp_unmapped", 32'(rs), 32'(`CME_RESP_SLVERR));
    axi_wr(`CME_ADDR_STATUS, 32'h0000_0000, rs);
    check("bresp_status", 32'(rs), 32'(`CME_RESP_SLVERR));
  endtask

  // program one timer, raise then lower one pin, and count strobes;
  // expected pairs are {after fall, after rise}
  task automatic run_case(input int t, p, input logic [7:0] c,
                          input logic [1:0] ea, ec);
    logic [31:0] d;
    logic [1:0] rs;
    int a0, c0;
    logic [31:0] a_addr;
    a_addr = (t == 1) ? `CME_ADDR_CTRL_T1 : `CME_ADDR_CTRL_T0;
    // upper bits always written as zero
    axi_wr(a_addr, {24'h00_0000, c}, rs);
    check("bresp", 32'(rs), 32'(`CME_RESP_OKAY));
    axi_rd(a_addr, d, rs);
    check("ctrl_readback", 32'(d[7:0]), 32'(c));
    check("prescale", 32'(o_prescale_adv[t]), 32'(c[1:0] == 2'h0));
    a0 = n_adv[t];
    c0 = n_clr[t];
    cme_pulse_src_i.drive(t * 2 + p, 1'b1);
    // the accepted level trails the pin by the three-stage sampler
    repeat (2) @(posedge i_clock);
    axi_rd(`CME_ADDR_STATUS, d, rs);
    check("status_level", 32'(d[t * 2 + p]), 32'h0000_0001);
    repeat (4) @(posedge i_clock);
    check("adv_rise", 32'(n_adv[t] - a0), 32'(ea[0]));
    check("clr_rise", 32'(n_clr[t] - c0), 32'(ec[0]));
    a0 = n_adv[t];
    c0 = n_clr[t];
    cme_pulse_src_i.drive(t * 2 + p, 1'b0);
    repeat (6) @(posedge i_clock);
    check("adv_fall", 32'(n_adv[t] - a0), 32'(ea[1]));
    check("clr_fall", 32'(n_clr[t] - c0), 32'(ec[1]));
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    i_reset <= 1'b1;
    i_s_axi_awaddr <= 32'h0000_0000;
    i_s_axi_awvalid <= 1'b0;
    i_s_axi_wdata <= 32'h0000_0000;
    i_s_axi_wstrb <= 4'h0;
    i_s_axi_wvalid <= 1'b0;
    i_s_axi_bready <= 1'b0;
    i_s_axi_araddr <= 32'h0000_0000;
    i_s_axi_arvalid <= 1'b0;
    i_s_axi_rready <= 1'b0;
    repeat (3) @(posedge i_clock);
    i_reset <= 1'b0;
    repeat (2) @(posedge i_clock);
    reset_and_map();
    run_case(0, 0, 8'h00, 2'h0, 2'h0);
    // capture control sits outside this block and is taken as 000
    run_case(0, 0, 8'h01, 2'h1, 2'h0);
    run_case(0, 0, 8'h02, 2'h2, 2'h0);
    run_case(0, 0, 8'h03, 2'h3, 2'h0);
    run_case(0, 1, 8'h09, 2'h1, 2'h0);
    run_case(0, 1, 8'h05, 2'h0, 2'h0);
    // timer1 setups use legal input codes; 0b below probes a reserved one
    run_case(1, 0, 8'h02, 2'h2, 2'h0);
    run_case(1, 1, 8'h07, 2'h3, 2'h0);
    run_case(1, 0, 8'h0b, 2'h0, 2'h0);
    // normal clear setups keep off the timer0 reserved codes; 50 and f0 below probe two of them
    run_case(0, 0, 8'h10, 2'h0, 2'h1);
    run_case(0, 0, 8'h30, 2'h0, 2'h2);
    run_case(0, 1, 8'h90, 2'h0, 2'h1);
    run_case(0, 1, 8'hb0, 2'h0, 2'h2);
    run_case(0, 0, 8'h50, 2'h0, 2'h0);
    run_case(0, 1, 8'hf0, 2'h0, 2'h0);
    run_case(0, 0, 8'h20, 2'h0, 2'h0);
    run_case(1, 0, 8'h30, 2'h0, 2'h2);
    run_case(1, 1, 8'h50, 2'h0, 2'h1);
    run_case(1, 1, 8'h70, 2'h0, 2'h2);
    run_case(1, 1, 8'h90, 2'h0, 2'h0);
    run_case(0, 0, 8'h11, 2'h1, 2'h1);
    run_case(0, 1, 8'h39, 2'h1, 2'h0);
    run_case(1, 1, 8'h05, 2'h1, 2'h0);
    run_case(0, 1, 8'h0b, 2'h3, 2'h0);
    run_case(1, 0, 8'h01, 2'h1, 2'h0);
    stop_test();
  end
endmodule
`default_nettype wire
